// ===== midmap_host.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Host model: APB master that reads the identification map.
// ---------------------------------------------------------------
module midmap_host (
	// Clock.
	input wire logic clk,
	// Requests towards the module.
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	// Answers from the module.
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// The bus stays idle from time zero.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end

	// One transfer; the request is held until pready is seen at an edge.
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		pstrb <= 4'hF;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~wd;
	endtask : xfer
endmodule : midmap_host

// ===== midmap_pkg.sv
package midmap_pkg;

	// ---------------------------------------------------------------
	// Register indices; the byte address on the bus is four times the index.
	// ---------------------------------------------------------------
	localparam logic [7:0] IDX_OPT_A = 8'hC2;
	localparam logic [7:0] IDX_OPT_B = 8'hC3;
	localparam logic [7:0] IDX_SERIAL = 8'hC4;
	localparam logic [7:0] IDX_SERIAL_LAST = 8'hD3;
	localparam logic [7:0] IDX_DATE = 8'hD4;
	localparam logic [7:0] IDX_DATE_LAST = 8'hDB;
	localparam logic [7:0] IDX_CTRL = 8'hE0;
	localparam logic [7:0] IDX_STATUS = 8'hE1;

	// ---------------------------------------------------------------
	// Field positions.
	// ---------------------------------------------------------------
	localparam int BIT_A_RX_OUT_DIS = 2;
	localparam int BIT_A_TX_SQ_DIS = 1;
	localparam int BIT_A_TX_SQ = 0;
	localparam int BIT_B_PAGE2 = 7;
	localparam int BIT_B_PAGE1 = 6;
	localparam int BIT_B_RATE_SEL = 5;
	localparam int BIT_B_TX_DIS = 4;
	localparam int BIT_B_TX_FAULT = 3;
	localparam int BIT_B_SQ_METHOD = 2;
	localparam int BIT_B_LOS = 1;
	localparam int BIT_CTRL_ERR_RO_WR = 0;
	localparam int BIT_ST_RO_WR = 0;
	localparam int BIT_ST_UNMAPPED = 1;

	// ---------------------------------------------------------------
	// Character codes and field sizes.
	// ---------------------------------------------------------------
	localparam logic [7:0] CHR_SPACE = 8'h20;
	localparam logic [7:0] CHR_ZERO = 8'h30;
	localparam logic [7:0] CHR_NINE = 8'h39;
	localparam int SERIAL_BYTES = 16;
	localparam int DATE_BYTES = 8;

	// ---------------------------------------------------------------
	// Reset values.
	// ---------------------------------------------------------------
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [1:0] STATUS_RESET = 2'h0;

	// Whole state of the register bank.
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [1:0] ctrl;
		logic [1:0] status;
	} midmap_state_s;

endpackage : midmap_pkg

// ===== midmap_regs.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module midmap_regs #(
	parameter bit RX_OUT_DIS = 1'b1,
	parameter bit TX_SQ_DIS = 1'b0,
	parameter bit TX_SQ = 1'b1,
	parameter bit PAGE2 = 1'b0,
	parameter bit PAGE1 = 1'b0,
	parameter bit RATE_SEL = 1'b0,
	parameter bit TX_DIS = 1'b1,
	parameter bit TX_FAULT = 1'b1,
	parameter bit SQ_METHOD = 1'b0,
	parameter bit LOS = 1'b1,
	// Serial text, first character in the top byte once justified; arbitrary.
	parameter logic [127:0] SERIAL_TEXT = "XY0000000001",
	// Year, month, day, lot; arbitrary.
	parameter logic [63:0] DATE_TEXT = "240115",
	parameter int PADDR_W = 12
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ---------------------------------------------------------------
	// Content shaping functions
	// ---------------------------------------------------------------

	// Moves characters to the top, fills the tail with spaces; zero stays zero.
	function automatic logic [127:0] justify_serial(input logic [127:0] v);
		logic [127:0] r;
		logic any;
		r = v;
		any = |v;
		for (int i = 0; i < midmap_pkg::SERIAL_BYTES; i++) begin
			if (any && r[127:120] == 8'h00) begin
				r = {r[119:0], 8'h00};
			end
		end
		for (int i = 0; i < midmap_pkg::SERIAL_BYTES; i++) begin
			if (any && r[i*8 +: 8] == 8'h00) begin
				r[i*8 +: 8] = midmap_pkg::CHR_SPACE;
			end
		end
		return r;
	endfunction : justify_serial

	// Fills missing date characters: digits become zero, lot becomes blank.
	function automatic logic [63:0] fill_date(input logic [63:0] v);
		logic [63:0] r;
		r = v;
		if (r[15:0] == 16'h0000 && r[63:16] != 48'h0) begin
			r = {r[47:0], 16'h0000};
		end
		for (int i = 0; i < midmap_pkg::DATE_BYTES; i++) begin
			if (r[i*8 +: 8] == 8'h00) begin
				r[i*8 +: 8] = (i < 2) ? midmap_pkg::CHR_SPACE : midmap_pkg::CHR_ZERO;
			end
		end
		return r;
	endfunction : fill_date

	// True for an ASCII decimal digit.
	function automatic logic is_digit(input logic [7:0] c);
		return c >= midmap_pkg::CHR_ZERO && c <= midmap_pkg::CHR_NINE;
	endfunction : is_digit

	// Two ASCII digits to a number.
	function automatic logic [6:0] two_digits(input logic [15:0] c);
		logic [3:0] hi;
		logic [3:0] lo;
		hi = c[11:8];
		lo = c[3:0];
		return 7'(hi) * 7'd10 + 7'(lo);
	endfunction : two_digits

	// ---------------------------------------------------------------
	// Fixed contents
	// ---------------------------------------------------------------
	localparam logic [127:0] SERIAL_ROM = justify_serial(SERIAL_TEXT);
	localparam logic [63:0] DATE_ROM = fill_date(DATE_TEXT);

	logic [7:0] opt_a;
	logic [7:0] opt_b;

	// Option capability bytes from the build options; unlisted bits read zero.
	always_comb begin
		opt_a = 8'h00;
		opt_b = 8'h00;
		opt_a[midmap_pkg::BIT_A_RX_OUT_DIS] = RX_OUT_DIS;
		opt_a[midmap_pkg::BIT_A_TX_SQ_DIS] = TX_SQ_DIS;
		opt_a[midmap_pkg::BIT_A_TX_SQ] = TX_SQ;
		opt_b[midmap_pkg::BIT_B_PAGE2] = PAGE2;
		opt_b[midmap_pkg::BIT_B_PAGE1] = PAGE1;
		opt_b[midmap_pkg::BIT_B_RATE_SEL] = RATE_SEL;
		opt_b[midmap_pkg::BIT_B_TX_DIS] = TX_DIS;
		opt_b[midmap_pkg::BIT_B_TX_FAULT] = TX_FAULT;
		opt_b[midmap_pkg::BIT_B_SQ_METHOD] = SQ_METHOD;
		opt_b[midmap_pkg::BIT_B_LOS] = LOS;
	end

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	logic [7:0] idx;
	logic aligned;
	logic hit_serial;
	logic hit_date;
	logic hit_ro;
	logic hit_rw;
	logic [3:0] sn_sel;
	logic [2:0] dt_sel;

	// Word index from the byte address; upper and lane bits must be zero.
	always_comb begin
		idx = paddr[9:2];
		aligned = (paddr[1:0] == 2'h0) && (paddr[PADDR_W-1:10] == '0);
		hit_serial = aligned && idx >= midmap_pkg::IDX_SERIAL
			&& idx <= midmap_pkg::IDX_SERIAL_LAST;
		hit_date = aligned && idx >= midmap_pkg::IDX_DATE && idx <= midmap_pkg::IDX_DATE_LAST;
		hit_ro = hit_serial || hit_date || (aligned && (idx == midmap_pkg::IDX_OPT_A
			|| idx == midmap_pkg::IDX_OPT_B));
		hit_rw = aligned && (idx == midmap_pkg::IDX_CTRL || idx == midmap_pkg::IDX_STATUS);
		sn_sel = 4'(idx - midmap_pkg::IDX_SERIAL);
		dt_sel = 3'(idx - midmap_pkg::IDX_DATE);
	end

	// Whole bus state and its next value.
	midmap_pkg::midmap_state_s st_q;
	midmap_pkg::midmap_state_s st_d;

	logic [7:0] rd_byte;

	// Read multiplexer; first character sits at the lowest index.
	always_comb begin
		rd_byte = 8'h00;
		if (hit_serial) begin
			rd_byte = SERIAL_ROM[8*(15 - int'(sn_sel)) +: 8];
		end else if (hit_date) begin
			rd_byte = DATE_ROM[8*(7 - int'(dt_sel)) +: 8];
		end else if (aligned && idx == midmap_pkg::IDX_OPT_A) begin
			rd_byte = opt_a;
		end else if (aligned && idx == midmap_pkg::IDX_OPT_B) begin
			rd_byte = opt_b;
		end else if (aligned && idx == midmap_pkg::IDX_CTRL) begin
			rd_byte = {6'h00, st_q.ctrl};
		end else if (aligned && idx == midmap_pkg::IDX_STATUS) begin
			rd_byte = {6'h00, st_q.status};
		end
	end

	// ---------------------------------------------------------------
	// Bus state
	// ---------------------------------------------------------------
	logic setup;
	logic access;
	logic ro_write;

	// Answer in the first access cycle; writes land at the completing edge.
	always_comb begin
		st_d = st_q;
		setup = psel && !penable;
		access = psel && penable && st_q.pready;
		ro_write = access && pwrite && hit_ro;
		st_d.pready = setup;
		if (setup) begin
			st_d.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
			st_d.pslverr = !(hit_ro || hit_rw)
				|| (pwrite && hit_ro && st_q.ctrl[midmap_pkg::BIT_CTRL_ERR_RO_WR]);
		end else if (access) begin
			st_d.pslverr = 1'b0;
		end
		// Status bits are write-one-to-clear; a new event wins over the clear.
		if (access && pwrite && hit_rw && pstrb[0]) begin
			if (idx == midmap_pkg::IDX_CTRL) begin
				st_d.ctrl = pwdata[1:0];
			end else begin
				st_d.status = st_q.status & ~pwdata[1:0];
			end
		end
		if (ro_write) begin
			st_d.status[midmap_pkg::BIT_ST_RO_WR] = 1'b1;
		end
		if (access && !(hit_ro || hit_rw)) begin
			st_d.status[midmap_pkg::BIT_ST_UNMAPPED] = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q <= '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0,
				ctrl: midmap_pkg::CTRL_RESET, status: midmap_pkg::STATUS_RESET};
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_read(logic [7:0] i);
		psel && !penable && !pwrite && aligned && idx == i;
	endsequence

	property p_opt_a_rx;
		s_read(midmap_pkg::IDX_OPT_A) |=> pready && prdata[2] == RX_OUT_DIS;
	endproperty
	a_opt_a_rx: assert property (p_opt_a_rx) else $error("Option A bit 2 wrong.");

	property p_opt_a_sq;
		s_read(midmap_pkg::IDX_OPT_A) |=> prdata[1:0] == {TX_SQ_DIS, TX_SQ};
	endproperty
	a_opt_a_sq: assert property (p_opt_a_sq) else $error("Option A squelch bits wrong.");

	property p_opt_b_pages;
		s_read(midmap_pkg::IDX_OPT_B) |=> prdata[7:5] == {PAGE2, PAGE1, RATE_SEL};
	endproperty
	a_opt_b_pages: assert property (p_opt_b_pages) else $error("Option B bits 7-5 wrong.");

	property p_opt_b_low;
		s_read(midmap_pkg::IDX_OPT_B) |=> prdata[4:0] == {TX_DIS, TX_FAULT, SQ_METHOD, LOS, 1'b0};
	endproperty
	a_opt_b_low: assert property (p_opt_b_low) else $error("Option B bits 4-0 wrong.");

	property p_serial_ascii;
		s_read(midmap_pkg::IDX_SERIAL_LAST) |=>
			prdata[7:0] == midmap_pkg::CHR_SPACE || prdata[7:0] >= 8'h21 || SERIAL_ROM == '0;
	endproperty
	a_serial_ascii: assert property (p_serial_ascii) else $error("Serial tail not padded.");

	property p_date_digits;
		s_read(midmap_pkg::IDX_DATE) |=> is_digit(prdata[7:0]) && prdata[31:8] == 24'h0;
	endproperty
	a_date_digits: assert property (p_date_digits) else $error("Year digit not ASCII.");

	property p_month;
		two_digits(DATE_ROM[47:32]) >= 7'd1 && two_digits(DATE_ROM[47:32]) <= 7'd12;
	endproperty
	a_month: assert property (p_month) else $error("Month out of range.");

	property p_day;
		two_digits(DATE_ROM[31:16]) >= 7'd1 && two_digits(DATE_ROM[31:16]) <= 7'd31;
	endproperty
	a_day: assert property (p_day) else $error("Day out of range.");

	property p_lot;
		s_read(midmap_pkg::IDX_DATE_LAST) |=> prdata[7:0] >= midmap_pkg::CHR_SPACE;
	endproperty
	a_lot: assert property (p_lot) else $error("Lot code not ASCII.");

	// Completing edge of a write aimed at a fixed field.
	sequence s_ro_write;
		psel && penable && pready && pwrite && hit_ro;
	endsequence

	// Setup cycle of a write aimed at a fixed field.
	sequence s_ro_setup;
		psel && !penable && pwrite && hit_ro;
	endsequence

	// Setup cycle whose address decodes to nothing.
	sequence s_unmapped_setup;
		psel && !penable && !(hit_ro || hit_rw);
	endsequence

	// Status and control copies watched by the assertions below.
	logic [1:0] status;
	logic [1:0] ctrl;
	assign status = st_q.status;
	assign ctrl = st_q.ctrl;

	// A completed write to a fixed field is recorded in status.
	property p_ro_write;
		s_ro_write |=> status[midmap_pkg::BIT_ST_RO_WR];
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("Write to fixed field not flagged.");

	// The error answer to such a write follows the control bit and carries no data.
	property p_ro_err;
		s_ro_setup |=> pready && prdata == 32'h0000_0000
			&& pslverr == ctrl[midmap_pkg::BIT_CTRL_ERR_RO_WR];
	endproperty
	a_ro_err: assert property (p_ro_err) else $error("Fixed field write answer wrong.");

	// A write to a fixed field leaves the control register alone.
	property p_ro_ctrl;
		s_ro_write |=> ctrl == $past(ctrl);
	endproperty
	a_ro_ctrl: assert property (p_ro_ctrl) else $error("Fixed field write changed control.");

	// An unmapped address answers with an error and zero data, then sets status.
	property p_unmapped;
		s_unmapped_setup |=> pready && pslverr && prdata == 32'h0000_0000
			##1 status[midmap_pkg::BIT_ST_UNMAPPED];
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused.");

	// Every answer comes in the first access cycle and lasts one cycle only.
	property p_one_cycle;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("Answer timing wrong.");

	// The first serial character is printable unless the whole field is zero.
	property p_serial_first;
		s_read(midmap_pkg::IDX_SERIAL) |=>
			prdata[7:0] > midmap_pkg::CHR_SPACE || SERIAL_ROM == '0;
	endproperty
	a_serial_first: assert property (p_serial_first) else $error("Serial not justified.");

endmodule : midmap_regs

// ===== midmap_tb_top.sv
`timescale 1ns/100ps
module midmap_tb_top;
	// ---------------------------------------------------------------
	// Bench signals and expected contents.
	// ---------------------------------------------------------------
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	int err_count = 0;
	int total_checks = 0;
	int cycles = 0;
	localparam logic [127:0] SN = "AB12";
	localparam logic [63:0] DT = "991231AB";
	// Capability pattern of the device under test; unlisted bits stay zero.
	localparam logic [7:0] OPT_A = 8'h03;
	localparam logic [7:0] OPT_B = 8'hAC;

	// Clock of 10 ns.
	initial forever #5 clk = ~clk;

	// Device under test with a mixed capability pattern.
	midmap_regs #(.RX_OUT_DIS(OPT_A[midmap_pkg::BIT_A_RX_OUT_DIS]),
		.TX_SQ_DIS(OPT_A[midmap_pkg::BIT_A_TX_SQ_DIS]), .TX_SQ(OPT_A[midmap_pkg::BIT_A_TX_SQ]),
		.PAGE2(OPT_B[midmap_pkg::BIT_B_PAGE2]), .PAGE1(OPT_B[midmap_pkg::BIT_B_PAGE1]),
		.RATE_SEL(OPT_B[midmap_pkg::BIT_B_RATE_SEL]), .TX_DIS(OPT_B[midmap_pkg::BIT_B_TX_DIS]),
		.TX_FAULT(OPT_B[midmap_pkg::BIT_B_TX_FAULT]),
		.SQ_METHOD(OPT_B[midmap_pkg::BIT_B_SQ_METHOD]), .LOS(OPT_B[midmap_pkg::BIT_B_LOS]),
		.SERIAL_TEXT(SN), .DATE_TEXT(DT)) midmap_regs_inst (.clk(clk),
		.nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// Host model on the management bus.
	midmap_host midmap_host_inst (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// Byte address of a map index.
	function automatic logic [11:0] adr(input int idx);
		return 12'(idx * 4);
	endfunction : adr

	// Compares one result and counts it.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Reads a word and checks data and error response.
	task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp,
		input logic exp_err);
		midmap_host_inst.xfer(1'b0, a, 32'h0, rd, err);
		chk(what, exp, rd);
		chk({what, "_err"}, {31'h0, exp_err}, {31'h0, err});
	endtask : rdchk

	// Writes a word and checks the error response.
	task automatic wrchk(input string what, input logic [11:0] a, input logic [31:0] d,
		input logic exp_err);
		midmap_host_inst.xfer(1'b1, a, d, rd, err);
		chk({what, "_err"}, {31'h0, exp_err}, {31'h0, err});
	endtask : wrchk

	// Prints the counts and the verdict, then stops.
	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up

	// A hang counts as a mismatch and ends the run.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			wrap_up();
		end
	end

	// ---------------------------------------------------------------
	// Test sequence.
	// ---------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rdchk("status", adr(midmap_pkg::IDX_STATUS), 32'h0, 1'b0);
		rdchk("ctrl", adr(midmap_pkg::IDX_CTRL), 32'h0, 1'b0);
		rdchk("opt_a", adr(midmap_pkg::IDX_OPT_A), {24'h0, OPT_A}, 1'b0);
		rdchk("opt_b", adr(midmap_pkg::IDX_OPT_B), {24'h0, OPT_B}, 1'b0);
		$display("test options done");
		for (int i = 0; i < 16; i++) begin
			rdchk("serial", adr(midmap_pkg::IDX_SERIAL + i),
				{24'h0, (i < 4) ? SN[8*(3-i)+:8] : midmap_pkg::CHR_SPACE}, 1'b0);
		end
		for (int i = 0; i < 8; i++) begin
			rdchk("date", adr(midmap_pkg::IDX_DATE + i), {24'h0, DT[8*(7-i)+:8]}, 1'b0);
		end
		$display("test text fields done");
		wrchk("opt_b_wr", adr(midmap_pkg::IDX_OPT_B), 32'h53, 1'b0);
		rdchk("opt_b_kept", adr(midmap_pkg::IDX_OPT_B), 32'hAC, 1'b0);
		rdchk("status_ro", adr(midmap_pkg::IDX_STATUS), 32'h1, 1'b0);
		wrchk("ctrl_wr", adr(midmap_pkg::IDX_CTRL), 32'h1, 1'b0);
		rdchk("ctrl_rb", adr(midmap_pkg::IDX_CTRL), 32'h1, 1'b0);
		wrchk("sn_wr", adr(midmap_pkg::IDX_SERIAL), 32'h5A, 1'b1);
		wrchk("date_wr", adr(midmap_pkg::IDX_DATE_LAST), 32'h30, 1'b1);
		rdchk("sn_kept", adr(midmap_pkg::IDX_SERIAL), 32'h41, 1'b0);
		rdchk("date_kept", adr(midmap_pkg::IDX_DATE_LAST), 32'h42, 1'b0);
		wrchk("clr", adr(midmap_pkg::IDX_STATUS), 32'h3, 1'b0);
		rdchk("status_clr", adr(midmap_pkg::IDX_STATUS), 32'h0, 1'b0);
		$display("test writes done");
		rdchk("below_map", adr(8'hC1), 32'h0, 1'b1);
		rdchk("after_date", adr(8'hDC), 32'h0, 1'b1);
		rdchk("misaligned", 12'h309, 32'h0, 1'b1);
		rdchk("status_unm", adr(midmap_pkg::IDX_STATUS), 32'h2, 1'b0);
		$display("test unmapped done");
		// A reset in mid-run returns control and status to zero.
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		rdchk("ctrl_rst", adr(midmap_pkg::IDX_CTRL), 32'h0, 1'b0);
		rdchk("status_rst", adr(midmap_pkg::IDX_STATUS), 32'h0, 1'b0);
		rdchk("opt_b_rst", adr(midmap_pkg::IDX_OPT_B), {24'h0, OPT_B}, 1'b0);
		$display("test reset done");
		wrap_up();
	end
endmodule : midmap_tb_top
